// >>> periodic_timer_cfg.svh
// Offsets, field positions, codes and reset values of the periodic timer
`ifndef PERIODIC_TIMER_CFG_SVH
`define PERIODIC_TIMER_CFG_SVH
`define PT_CNT_W        10
`define PT_CNT_MAX      10'h3FF
`define PT_ADDR_W       8
`define PT_OFF_CTRL0    8'h00
`define PT_OFF_CTRL1    8'h04
`define PT_OFF_CNT_LO   8'h08
`define PT_OFF_CNT_HI   8'h0C
`define PT_OFF_CMPA_LO  8'h10
`define PT_OFF_CMPA_HI  8'h14
`define PT_OFF_PER_LO   8'h18
`define PT_OFF_PER_HI   8'h1C
`define PT_OFF_STATUS   8'h20
`define PT_CTRL0_ON_BIT 3
`define PT_STAT_A_BIT   0
`define PT_STAT_P_BIT   1
`define PT_CTRL1_RST    8'h00
`define PT_MODE_CMP     2'h0
`define PT_MODE_CAP     2'h1
`define PT_MODE_PWM     2'h2
`define PT_MODE_TMR     2'h3
`define PT_ACT_00       2'h0
`define PT_ACT_01       2'h1
`define PT_ACT_10       2'h2
`define PT_ACT_11       2'h3
`endif

// >>> periodic_timer_pkg.sv
// Types shared by the periodic timer
package periodic_timer_pkg;
  typedef struct packed {
    logic [1:0] mode_sel;
    logic [1:0] output_action_sel;
    logic       output_initial_level;
    logic       output_invert;
    logic       capture_source_sel;
    logic       clear_source_sel;
  } ctrl1_t;
endpackage

// >>> periodic_timer_compare_output.sv
// Periodic 10-bit timer with compare output, capture and APB registers
`timescale 1ns/1ns
`default_nettype none
`include "periodic_timer_cfg.svh"

module periodic_timer_compare_output (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`PT_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Pins
  input  wire logic                  capture_input_pin,
  input  wire logic                  external_clock_pin,
  output logic                       timer_output_pin,
  output logic                       timer_output_oe,
  // Status
  output logic                       match_a_flag,
  output logic                       match_p_flag
);
  periodic_timer_pkg::ctrl1_t ctrl1;
  logic                   counter_on;
  logic                   on_prev;
  logic [`PT_CNT_W-1:0]   count;
  logic [`PT_CNT_W-1:0]   compare_a_value;
  logic [`PT_CNT_W-1:0]   period_value;
  logic                   out_lvl;
  logic                   cap_m;
  logic                   cap_s;
  logic                   cap_d;
  logic                   eck_m;
  logic                   eck_s;
  logic                   eck_d;
  logic                   wr;
  logic                   setup_rd;
  logic                   hit_a;
  logic                   hit_p;
  logic                   ovf;
  logic                   clr_cnt;
  logic                   set_a;
  logic                   set_p;
  logic                   cap_evt;
  logic                   src_now;
  logic                   src_old;
  logic                   on_rise;
  logic                   pulse_end;
  logic                   cmp_mode;
  logic                   next_pin;
  logic                   next_oe;
  logic [31:0]            next_rdata;
  logic                   mapped;

  function automatic logic is_mapped(input logic [`PT_ADDR_W-1:0] a);
    is_mapped = (a == `PT_OFF_CTRL0) || (a == `PT_OFF_CTRL1) ||
                (a == `PT_OFF_CNT_LO) || (a == `PT_OFF_CNT_HI) ||
                (a == `PT_OFF_CMPA_LO) || (a == `PT_OFF_CMPA_HI) ||
                (a == `PT_OFF_PER_LO) || (a == `PT_OFF_PER_HI) ||
                (a == `PT_OFF_STATUS);
  endfunction

  // APB handshake: zero wait states
  assign pready   = psel & penable;
  assign mapped   = is_mapped(paddr);
  assign pslverr  = psel & penable & ~mapped;
  assign wr       = psel & penable & pwrite & mapped;
  assign setup_rd = psel & ~penable & ~pwrite;

  // Pin synchronisers, first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_m <= 1'b0;
      cap_s <= 1'b0;
      cap_d <= 1'b0;
      eck_m <= 1'b0;
      eck_s <= 1'b0;
      eck_d <= 1'b0;
    end else begin
      cap_m <= capture_input_pin;
      cap_s <= cap_m;
      cap_d <= cap_s;
      eck_m <= external_clock_pin;
      eck_s <= eck_m;
      eck_d <= eck_s;
    end
  end

  // Match and clear decode
  assign cmp_mode = (ctrl1.mode_sel == `PT_MODE_CMP) ||
                    (ctrl1.mode_sel == `PT_MODE_TMR);
  assign on_rise  = counter_on & ~on_prev;
  // Start cycle still holds the residual count, so no match may fire in it
  assign ovf      = counter_on & on_prev & (count == `PT_CNT_MAX);
  // Zero compare A never matches; under A clear the counter just wraps
  assign hit_a    = counter_on & on_prev & (compare_a_value != '0) &
                    (count == compare_a_value);
  // Zero period means full range: P hit at overflow
  assign hit_p    = (period_value == '0) ? ovf
                    : counter_on & on_prev & (count == period_value);

  always_comb begin
    clr_cnt = 1'b0;
    set_a   = 1'b0;
    set_p   = 1'b0;
    if (cmp_mode) begin
      if (ctrl1.clear_source_sel) begin
        clr_cnt = hit_a;
        set_a   = hit_a;
      end else begin
        clr_cnt = hit_p;
        set_a   = hit_a;
        set_p   = hit_p;
      end
    end else if (ctrl1.mode_sel == `PT_MODE_CAP) begin
      clr_cnt = hit_p;
      set_a   = cap_evt;
      set_p   = hit_p;
    end else begin
      clr_cnt = hit_p;
      set_a   = hit_a;
      set_p   = hit_p;
    end
  end

  // Capture edge selection
  assign src_now = ctrl1.capture_source_sel ? eck_s : cap_s;
  assign src_old = ctrl1.capture_source_sel ? eck_d : cap_d;
  always_comb begin
    unique case (ctrl1.output_action_sel)
      `PT_ACT_00: cap_evt = src_now & ~src_old;
      `PT_ACT_01: cap_evt = ~src_now & src_old;
      `PT_ACT_10: cap_evt = src_now ^ src_old;
      `PT_ACT_11: cap_evt = 1'b0;
    endcase
    cap_evt = cap_evt & counter_on & (ctrl1.mode_sel == `PT_MODE_CAP);
  end

  // Single pulse ends on A match
  assign pulse_end = (ctrl1.mode_sel == `PT_MODE_PWM) &&
                     (ctrl1.output_action_sel == `PT_ACT_11) && hit_a;

  // Control registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1 <= periodic_timer_pkg::ctrl1_t'(`PT_CTRL1_RST);
    end else if (wr && paddr == `PT_OFF_CTRL1) begin
      ctrl1 <= periodic_timer_pkg::ctrl1_t'(pwdata[7:0]);
    end
  end

  // Software write wins over the pulse end in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      counter_on <= 1'b0;
    end else if (wr && paddr == `PT_OFF_CTRL0) begin
      counter_on <= pwdata[`PT_CTRL0_ON_BIT];
    end else if (pulse_end) begin
      counter_on <= 1'b0;
    end else if ((ctrl1.mode_sel == `PT_MODE_PWM) &&
                 (ctrl1.output_action_sel == `PT_ACT_11) && eck_s && !eck_d) begin
      counter_on <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      on_prev <= 1'b0;
    end else begin
      on_prev <= counter_on;
    end
  end

  // Counter: one count per clock while on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (on_rise) begin
      count <= '0;
    end else if (counter_on) begin
      if (clr_cnt) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  // Compare A: written by software, loaded by capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      compare_a_value <= '0;
    end else if (cap_evt) begin
      compare_a_value <= count;
    end else if (wr && paddr == `PT_OFF_CMPA_LO) begin
      compare_a_value[7:0] <= pwdata[7:0];
    end else if (wr && paddr == `PT_OFF_CMPA_HI) begin
      compare_a_value[9:8] <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      period_value <= '0;
    end else if (wr && paddr == `PT_OFF_PER_LO) begin
      period_value[7:0] <= pwdata[7:0];
    end else if (wr && paddr == `PT_OFF_PER_HI) begin
      period_value[9:8] <= pwdata[1:0];
    end
  end

  // Sticky flags, write one to clear, a new event wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      match_a_flag <= (match_a_flag & ~(wr && paddr == `PT_OFF_STATUS &&
                       pwdata[`PT_STAT_A_BIT])) | set_a;
      match_p_flag <= (match_p_flag & ~(wr && paddr == `PT_OFF_STATUS &&
                       pwdata[`PT_STAT_P_BIT])) | set_p;
    end
  end

  // Compare output level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_lvl <= 1'b0;
    end else if (on_rise) begin
      out_lvl <= ctrl1.output_initial_level;
    end else if (ctrl1.mode_sel == `PT_MODE_CMP && set_a) begin
      unique case (ctrl1.output_action_sel)
        `PT_ACT_00: out_lvl <= out_lvl;
        `PT_ACT_01: out_lvl <= 1'b0;
        `PT_ACT_10: out_lvl <= 1'b1;
        `PT_ACT_11: out_lvl <= ~out_lvl;
      endcase
    end
  end

  // Pin drive; action changes while running may glitch the PWM
  always_comb begin
    next_pin = 1'b0;
    next_oe  = 1'b0;
    unique case (ctrl1.mode_sel)
      `PT_MODE_CMP: begin
        next_pin = out_lvl ^ ctrl1.output_invert;
        next_oe  = 1'b1;
      end
      `PT_MODE_PWM: begin
        unique case (ctrl1.output_action_sel)
          `PT_ACT_00: next_pin = ~ctrl1.output_initial_level;
          `PT_ACT_01: next_pin = ctrl1.output_initial_level;
          `PT_ACT_10: next_pin = (count < compare_a_value) ?
                                 ctrl1.output_initial_level
                                 : ~ctrl1.output_initial_level;
          `PT_ACT_11: next_pin = counter_on ?
                                 ctrl1.output_initial_level
                                 : ~ctrl1.output_initial_level;
        endcase
        next_pin = next_pin ^ ctrl1.output_invert;
        next_oe  = 1'b1;
      end
      `PT_MODE_CAP: begin
        next_pin = 1'b0;
        next_oe  = 1'b0;
      end
      `PT_MODE_TMR: begin
        next_pin = 1'b0;
        next_oe  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_output_pin <= 1'b0;
      timer_output_oe  <= 1'b0;
    end else begin
      timer_output_pin <= next_pin;
      timer_output_oe  <= next_oe;
    end
  end

  // Read mux, captured in the setup cycle
  always_comb begin
    next_rdata = '0;
    unique case (paddr)
      `PT_OFF_CTRL0:   next_rdata[`PT_CTRL0_ON_BIT] = counter_on;
      `PT_OFF_CTRL1:   next_rdata[7:0] = ctrl1;
      `PT_OFF_CNT_LO:  next_rdata[7:0] = count[7:0];
      `PT_OFF_CNT_HI:  next_rdata[1:0] = count[9:8];
      `PT_OFF_CMPA_LO: next_rdata[7:0] = compare_a_value[7:0];
      `PT_OFF_CMPA_HI: next_rdata[1:0] = compare_a_value[9:8];
      `PT_OFF_PER_LO:  next_rdata[7:0] = period_value[7:0];
      `PT_OFF_PER_HI:  next_rdata[1:0] = period_value[9:8];
      `PT_OFF_STATUS: begin
        next_rdata[`PT_STAT_A_BIT] = match_a_flag;
        next_rdata[`PT_STAT_P_BIT] = match_p_flag;
      end
      default:         next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
    end else if (setup_rd) begin
      prdata <= next_rdata;
    end
  end

  // Checks
  on_rise_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    on_rise |=> count == '0) else $error("counter not zeroed on start");
  off_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !counter_on && !on_rise && !$past(counter_on) |=> $stable(count))
    else $error("stopped counter moved");
  act_low_a: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl1.mode_sel == 2'h0 && set_a && !on_rise && ctrl1.output_action_sel == 2'h1
    |=> !out_lvl) else $error("match did not drive low");
  act_tog_a: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl1.mode_sel == 2'h0 && set_a && !on_rise && ctrl1.output_action_sel == 2'h3
    |=> out_lvl != $past(out_lvl)) else $error("match did not toggle");
  init_lvl_a: assert property (@(posedge clk) disable iff (!arst_n)
    on_rise |=> out_lvl == $past(ctrl1.output_initial_level))
    else $error("start did not restore level");
  tmr_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    $past(ctrl1.mode_sel) == 2'h3 |-> !timer_output_oe && !timer_output_pin)
    else $error("pin driven in timer mode");
  pin_inv_a: assert property (@(posedge clk) disable iff (!arst_n)
    $past(ctrl1.mode_sel) == 2'h0
    |-> timer_output_pin == ($past(out_lvl) ^ $past(ctrl1.output_invert)))
    else $error("compare pin level wrong");
  no_p_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl1.mode_sel == 2'h0 && ctrl1.clear_source_sel && !match_p_flag
    |=> !match_p_flag) else $error("P flag raised with A clear");
  zero_a_a: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl1.mode_sel == 2'h0 && compare_a_value == '0 && !match_a_flag
    |=> !match_a_flag) else $error("A flag with zero compare");
  ovf_clr_a: assert property (@(posedge clk) disable iff (!arst_n)
    counter_on && !on_rise && count == 10'h3FF |=> count == '0)
    else $error("no wrap at full count");
  cap_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    cap_evt |=> compare_a_value == $past(count) ##0 match_a_flag)
    else $error("capture lost");
endmodule
`default_nettype wire

// >>> pin_model.sv
// Pin-side partner that drives the timer's capture and clock pins
`timescale 1ns/1ns
`default_nettype none
module pin_model (
  // Clock
  input  wire logic clk,
  // Pins toward the timer
  output var  logic capture_input_pin,
  output var  logic external_clock_pin
);
  // Both pins idle low outside the scenarios that pulse them
  initial begin
    capture_input_pin = 1'b0;
    external_clock_pin = 1'b0;
  end

  // Level held four clocks, since the timer synchronises through two flops
  task automatic edge_on(input logic sel, input logic v);
    @(posedge clk);
    if (sel)
      external_clock_pin <= v;
    else
      capture_input_pin <= v;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> periodic_timer_compare_output_bench.sv
// Self-checking bench for the periodic timer with compare output
`timescale 1ns/1ns
`default_nettype none
`include "periodic_timer_cfg.svh"
module periodic_timer_compare_output_bench;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cap_pin;
  logic        ck_pin;
  logic        out_pin;
  logic        out_oe;
  logic        flag_a;
  logic        flag_p;
  int          err_count = 0;
  int          checks = 0;
  logic [31:0] lfsr = 32'h00017631;
  logic [31:0] rd;
  logic [31:0] hold;
  logic        err;
  logic [9:0]  av;
  logic        lv;
  int          n;

  always #5 clk = ~clk;

  periodic_timer_compare_output u_dut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(cap_pin), .external_clock_pin(ck_pin), .timer_output_pin(out_pin),
    .timer_output_oe(out_oe), .match_a_flag(flag_a), .match_p_flag(flag_p)
  );

  pin_model u_pins (
    .clk                (clk),
    .capture_input_pin  (cap_pin),
    .external_clock_pin (ck_pin)
  );

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Pin level after an A match in compare mode, before inversion
  function automatic logic cmp_lvl(input logic [1:0] act, input logic ini);
    return (act == 2'h0) ? ini : (act == 2'h3) ? ~ini : act[1];
  endfunction

  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] e);
    checks++;
    if (seen !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(w, rd, e);
  endtask

  task automatic set10(input logic [7:0] a, input logic [9:0] v);
    apb(1'b1, a, {24'h0, v[7:0]});
    apb(1'b1, a + 8'h04, {30'h0, v[9:8]});
  endtask

  task automatic setup(input logic [1:0] md, input logic [1:0] act, input logic [3:0] b);
    apb(1'b1, `PT_OFF_CTRL0, 32'h0);
    apb(1'b1, `PT_OFF_CTRL1, {24'h0, md, act, b});
    apb(1'b1, `PT_OFF_STATUS, 32'h3);
  endtask

  task automatic run_on;
    apb(1'b1, `PT_OFF_CTRL0, 32'h8);
  endtask

  task automatic wait_a(input int lim);
    for (int k = 0; k < lim && flag_a !== 1'b1; k++) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Generous bound: the whole run is under 5k cycles, the limit 40k
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      rchk("reset_val", 8'(i * 4), 32'h0);
    end
    apb(1'b0, 8'h24, 32'h0);
    check("hole_err", 32'(err), 32'h1);
    for (int i = 4; i < 8; i++) begin
      lfsr = step(lfsr);
      apb(1'b1, 8'(i * 4), lfsr);
      rchk("byte_mask", 8'(i * 4), lfsr & (i[0] ? 32'h3 : 32'hFF));
    end
    apb(1'b1, `PT_OFF_CNT_LO, 32'hFF);
    rchk("cnt_ro", `PT_OFF_CNT_LO, 32'h0);
    // Every action, initial level and inversion in compare mode
    for (int m = 0; m < 16; m++) begin
      lfsr = step(lfsr);
      av = 10'h00A + {6'h0, lfsr[3:0]};
      set10(`PT_OFF_CMPA_LO, av);
      set10(`PT_OFF_PER_LO, 10'h064);
      setup(2'h0, m[3:2], {m[1:0], 2'h0});
      run_on();
      repeat (2) @(posedge clk);
      check("init_pin", 32'(out_pin), 32'(m[1] ^ m[0]));
      check("cmp_oe", 32'(out_oe), 32'h1);
      wait_a(60);
      check("cmp_aflag", 32'(flag_a), 32'h1);
      repeat (3) @(posedge clk);
      lv = cmp_lvl(m[3:2], m[1]) ^ m[0];
      check("match_pin", 32'(out_pin), 32'(lv));
      for (int k = 0; k < 200 && flag_p !== 1'b1; k++) @(posedge clk);
      check("cmp_pflag", 32'(flag_p), 32'h1);
      check("p_no_pin", 32'(out_pin), 32'(lv));
      apb(1'b1, `PT_OFF_CTRL0, 32'h0);
      apb(1'b0, `PT_OFF_CNT_LO, 32'h0);
      hold = rd;
      rchk("cnt_hold", `PT_OFF_CNT_LO, hold);
      run_on();
      repeat (2) @(posedge clk);
      check("restart_pin", 32'(out_pin), 32'(m[1] ^ m[0]));
      apb(1'b0, `PT_OFF_CNT_LO, 32'h0);
      check("cnt_zeroed", 32'(rd < {22'h0, av}), 32'h1);
    end
    setup(2'h3, 2'h1, 4'hC);
    run_on();
    wait_a(60);
    check("tmr_flag", 32'(flag_a), 32'h1);
    check("tmr_oe", 32'(out_oe), 32'h0);
    // Period below compare A, under both clear sources
    set10(`PT_OFF_CMPA_LO, 10'h00C);
    set10(`PT_OFF_PER_LO, 10'h005);
    for (int c = 0; c < 2; c++) begin
      setup(2'h0, 2'h3, {3'h0, c[0]});
      run_on();
      repeat (4) begin
        apb(1'b0, `PT_OFF_CNT_LO, 32'h0);
        check("cnt_bound", 32'(rd <= (c[0] ? 32'hC : 32'h5)), 32'h1);
      end
      repeat (60) @(posedge clk);
      check("clr_pflag", 32'(flag_p), 32'(!c[0]));
      check("clr_aflag", 32'(flag_a), 32'(c[0]));
    end
    // Zero compare value written on purpose
    set10(`PT_OFF_CMPA_LO, 10'h000);
    set10(`PT_OFF_PER_LO, 10'h000);
    setup(2'h0, 2'h3, 4'h0);
    run_on();
    repeat (1100) @(posedge clk);
    check("zero_aflag", 32'(flag_a), 32'h0);
    check("ovf_pflag", 32'(flag_p), 32'h1);
    // Each edge choice from each source pin, clear source set
    for (int s = 0; s < 8; s++) begin
      setup(2'h1, s[2:1], {2'h0, s[0], 1'b1});
      run_on();
      u_pins.edge_on(~s[0], 1'b1);
      u_pins.edge_on(~s[0], 1'b0);
      check("cap_other", 32'(flag_a), 32'h0);
      u_pins.edge_on(s[0], 1'b1);
      check("cap_rise", 32'(flag_a), 32'(s[2:1] == 2'h0 || s[2:1] == 2'h2));
      apb(1'b1, `PT_OFF_STATUS, 32'h3);
      u_pins.edge_on(s[0], 1'b0);
      check("cap_fall", 32'(flag_a), 32'(s[2:1] == 2'h1 || s[2:1] == 2'h2));
    end
    set10(`PT_OFF_CMPA_LO, 10'h00A);
    set10(`PT_OFF_PER_LO, 10'h014);
    for (int f = 0; f < 8; f++) begin
      setup(2'h2, {1'b0, f[2]}, {f[1:0], 2'h0});
      run_on();
      repeat (3) @(posedge clk);
      check("pwm_force", 32'(out_pin), 32'(!(f[2] ^ f[1]) ^ f[0]));
    end
    // Clear source set on purpose: an A clear would give a duty of 10 high cycles in 11
    setup(2'h2, 2'h2, 4'h9);
    run_on();
    n = 0;
    repeat (105) begin
      @(posedge clk);
      if (out_pin === 1'b1) n++;
    end
    check("pwm_duty", 32'(n >= 44 && n <= 56), 32'h1);
    setup(2'h2, 2'h3, 4'h8);
    run_on();
    repeat (2) @(posedge clk);
    check("pulse_lead", 32'(out_pin), 32'h1);
    wait_a(60);
    repeat (3) @(posedge clk);
    check("pulse_trail", 32'(out_pin), 32'h0);
    rchk("pulse_off", `PT_OFF_CTRL0, 32'h0);
    u_pins.edge_on(1'b1, 1'b1);
    repeat (2) @(posedge clk);
    check("pulse_trig", 32'(out_pin), 32'h1);
    u_pins.edge_on(1'b1, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
